// ### io_line_pkg.sv
// Constants for the upper register group of the 32-line I/O controller.
// Assumes a 32-bit AXI4-Lite slave with byte addresses taken from the low address bits.
package io_line_pkg;
    // ==========================================================================
    // Register byte offsets
    // ==========================================================================
    localparam logic [7:0] OFF_CHANGE_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] OFF_CHANGE_IRQ_DISABLE = 8'h04;
    localparam logic [7:0] OFF_CHANGE_IRQ_MASK_STATUS = 8'h08;
    localparam logic [7:0] OFF_CHANGE_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFF_OPEN_DRAIN_ENABLE = 8'h10;
    localparam logic [7:0] OFF_OPEN_DRAIN_DISABLE = 8'h14;
    localparam logic [7:0] OFF_OPEN_DRAIN_STATUS = 8'h18;
    localparam logic [7:0] OFF_PULLUP_DISABLE = 8'h20;
    localparam logic [7:0] OFF_PULLUP_ENABLE = 8'h24;
    localparam logic [7:0] OFF_PULLUP_STATUS = 8'h28;
    localparam logic [7:0] OFF_FUNCTION_A_SELECT = 8'h30;
    localparam logic [7:0] OFF_FUNCTION_B_SELECT = 8'h34;
    localparam logic [7:0] OFF_FUNCTION_SELECT_STATUS = 8'h38;
    localparam logic [7:0] OFF_DIRECT_WRITE_ENABLE = 8'h40;
    localparam logic [7:0] OFF_DIRECT_WRITE_DISABLE = 8'h44;
    localparam logic [7:0] OFF_DIRECT_WRITE_STATUS = 8'h48;
    localparam logic [7:0] OFF_OUTPUT_LEVEL_VALUE = 8'h50;

    // ==========================================================================
    // Values after reset and bus answers
    // ==========================================================================
    localparam logic [31:0] RST_MASK = 32'h0000_0000;
    localparam logic [31:0] RST_CHANGE = 32'h0000_0000;
    localparam logic [31:0] RST_OPEN_DRAIN = 32'h0000_0000;
    localparam logic [31:0] RST_PULLUP_OFF = 32'h0000_0000;
    localparam logic [31:0] RST_FUNC_B = 32'h0000_0000;
    localparam logic [31:0] RST_DIRECT_WRITE = 32'h0000_0000;
    localparam logic [31:0] RST_OUTPUT_LEVEL = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### pin_change_sync.sv
// Two-flop synchroniser for the pin levels plus a change detector per line.
// Assumes the pins are asynchronous to clock; only the second stage and later are read.
module pin_change_sync
    import io_line_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] pinLevel,
    output logic [WIDTH-1:0] syncLevel,
    output logic [WIDTH-1:0] levelChange
);
    // ==========================================================================
    // Synchroniser and previous-level stage
    // ==========================================================================
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] stable_reg;
    logic [WIDTH-1:0] prev_reg;

    // The first stage feeds only the second, so metastability cannot reach the detector.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= '0;
            stable_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= pinLevel;
            stable_reg <= meta_reg;
            prev_reg <= stable_reg;
        end
    end

    // A change is any difference between two successive settled samples.
    assign syncLevel = stable_reg;
    assign levelChange = stable_reg ^ prev_reg;
endmodule // pin_change_sync

// ### io_line_controller_upper_regs.sv
// Upper register group of a 32-line I/O controller: change interrupt, open drain,
// pull-up, function select and direct-write gating, behind an AXI4-Lite slave.
// Assumes pin inputs are asynchronous; PIO enable, output enable and peripheral
// drive come from same-clock logic elsewhere.
// Contract
// R1 - Mask status reads back which lines have change interrupt enabled.
// R2 - A detected level change sets the line's status bit, held until cleared.
// R3 - Reading change status or reset clears all status bits.
// R4 - Writing 1 to open drain enable turns open drain on; 0 no effect.
// R5 - Writing 1 to open drain disable turns open drain off; 0 no effect.
// R6 - Open-drain lines only drive low, released instead of high.
// R7 - Push-pull lines drive both levels from the output data.
// R8 - Writing 1 to pull-up disable switches pull-up off; 0 no effect.
// R9 - Writing 1 to pull-up enable switches pull-up on; 0 no effect.
// R10 - Pull-up status reads 0 when enabled, 1 when disabled.
// R11 - Writing 1 to function A select routes line to function A.
// R12 - Writing 1 to function B select routes line to function B.
// R13 - Function select status reads 0 for A, 1 for B.
// R14 - Writing 1 to direct write enable lets output data writes reach line.
// R15 - Writing 1 to direct write disable blocks output data writes for line.
// R16 - Direct write status reads 1 where output data writes take effect.
// R17 - Mask set by interrupt enable write, cleared by interrupt disable write.
// R18 - Output data holds the level to drive: 1 high, 0 low.
// R19 - Interrupt output high while any line has status and mask both set.
// R20 - A set arriving with a clear in the same cycle wins.
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
module io_line_controller_upper_regs
    import io_line_pkg::*;
#(
    parameter int LINES = 32
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [LINES-1:0] pinIn,
    output logic [LINES-1:0] pinOut,
    output logic [LINES-1:0] pinOutEn,
    output logic [LINES-1:0] pullupOn,
    output logic [LINES-1:0] lineLevel,
    input wire logic [LINES-1:0] pioEnable,
    input wire logic [LINES-1:0] pioOutputEnable,
    input wire logic [LINES-1:0] funcAData,
    input wire logic [LINES-1:0] funcAOutEn,
    input wire logic [LINES-1:0] funcBData,
    input wire logic [LINES-1:0] funcBOutEn,
    output logic changeIrq
);
    // ==========================================================================
    // State
    // ==========================================================================
    logic [LINES-1:0] mask_reg;
    logic [LINES-1:0] change_reg;
    logic [LINES-1:0] change_next;
    logic [LINES-1:0] openDrain_reg;
    logic [LINES-1:0] pullupOff_reg;
    logic [LINES-1:0] funcB_reg;
    logic [LINES-1:0] directWrite_reg;
    logic [LINES-1:0] outLevel_reg;
    logic [LINES-1:0] levelChange;
    logic [LINES-1:0] padData;
    logic [LINES-1:0] padEn;
    logic awHeld_reg;
    logic wHeld_reg;
    logic [7:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic bValid_reg;
    logic [1:0] bResp_reg;
    logic rValid_reg;
    logic [31:0] rData_reg;
    logic [1:0] rResp_reg;
    logic irq_reg;
    logic [LINES-1:0] pinOut_reg;
    logic [LINES-1:0] pinOutEn_reg;
    logic writeDo;
    logic readDo;
    logic [LINES-1:0] wBits;
    logic readClear;
    logic [31:0] rdValue;
    logic rdHit;
    logic wrHit;

    // ==========================================================================
    // Pin synchroniser
    // ==========================================================================
    pin_change_sync #(.WIDTH(LINES)) pinSync (
        .clock(clock),
        .reset_n(reset_n),
        .pinLevel(pinIn),
        .syncLevel(lineLevel),
        .levelChange(levelChange)
    );

    // ==========================================================================
    // AXI4-Lite write channel
    // ==========================================================================
    // One write is held at a time; address and data may arrive in either order.
    assign s_axi_awready = !awHeld_reg;
    assign s_axi_wready = !wHeld_reg;
    assign writeDo = awHeld_reg && wHeld_reg && !bValid_reg;
    assign s_axi_bvalid = bValid_reg;
    assign s_axi_bresp = bResp_reg;

    // Write bits with byte strobes applied, so an unstrobed lane has no effect.
    always_comb begin
        wBits = '0;
        for (int b = 0; b < 4; b++) begin
            if (wStrb_reg[b]) begin
                wBits[b*8 +: 8] = wData_reg[b*8 +: 8];
            end
        end
    end

    // Capture address and data, then answer once both are in.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= 8'h00;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
            bValid_reg <= 1'b0;
            bResp_reg <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (writeDo) begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                bValid_reg <= 1'b1;
                bResp_reg <= wrHit ? RESP_OKAY : RESP_SLVERR;
            end else if (bValid_reg && s_axi_bready) begin
                bValid_reg <= 1'b0;
            end
        end
    end

    // Writable offsets; status registers ignore writes but still answer OKAY.
    always_comb begin
        unique case ({awAddr_reg[7:2], 2'b00})
            OFF_CHANGE_IRQ_ENABLE, OFF_CHANGE_IRQ_DISABLE, OFF_CHANGE_IRQ_MASK_STATUS,
            OFF_CHANGE_IRQ_STATUS, OFF_OPEN_DRAIN_ENABLE, OFF_OPEN_DRAIN_DISABLE,
            OFF_OPEN_DRAIN_STATUS, OFF_PULLUP_DISABLE, OFF_PULLUP_ENABLE, OFF_PULLUP_STATUS,
            OFF_FUNCTION_A_SELECT, OFF_FUNCTION_B_SELECT, OFF_FUNCTION_SELECT_STATUS,
            OFF_DIRECT_WRITE_ENABLE, OFF_DIRECT_WRITE_DISABLE, OFF_DIRECT_WRITE_STATUS,
            OFF_OUTPUT_LEVEL_VALUE: wrHit = 1'b1;
            default: wrHit = 1'b0;
        endcase
    end

    // ==========================================================================
    // Configuration registers
    // ==========================================================================
    // Each set/clear pair updates only the lines written with 1.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mask_reg <= RST_MASK;
            openDrain_reg <= RST_OPEN_DRAIN;
            pullupOff_reg <= RST_PULLUP_OFF;
            funcB_reg <= RST_FUNC_B;
            directWrite_reg <= RST_DIRECT_WRITE;
            outLevel_reg <= RST_OUTPUT_LEVEL;
        end else if (writeDo) begin
            unique case ({awAddr_reg[7:2], 2'b00})
                // R17 mask set and clear
                OFF_CHANGE_IRQ_ENABLE: mask_reg <= mask_reg | wBits;
                OFF_CHANGE_IRQ_DISABLE: mask_reg <= mask_reg & ~wBits;
                // R4 open drain on
                OFF_OPEN_DRAIN_ENABLE: openDrain_reg <= openDrain_reg | wBits;
                // R5 open drain off
                OFF_OPEN_DRAIN_DISABLE: openDrain_reg <= openDrain_reg & ~wBits;
                // R8 pull-up off
                OFF_PULLUP_DISABLE: pullupOff_reg <= pullupOff_reg | wBits;
                // R9 pull-up on
                OFF_PULLUP_ENABLE: pullupOff_reg <= pullupOff_reg & ~wBits;
                // R11 route to A
                OFF_FUNCTION_A_SELECT: funcB_reg <= funcB_reg & ~wBits;
                // R12 route to B
                OFF_FUNCTION_B_SELECT: funcB_reg <= funcB_reg | wBits;
                // R14 allow direct writes
                OFF_DIRECT_WRITE_ENABLE: directWrite_reg <= directWrite_reg | wBits;
                // R15 block direct writes
                OFF_DIRECT_WRITE_DISABLE: directWrite_reg <= directWrite_reg & ~wBits;
                // R18 gated output data write
                OFF_OUTPUT_LEVEL_VALUE: begin
                    outLevel_reg <= (outLevel_reg & ~(directWrite_reg & byteMask(wStrb_reg)))
                        | (wBits & directWrite_reg);
                end
                default: ;
            endcase
        end
    end

    // Expand byte strobes into a per-line mask for the output data write.
    function automatic logic [31:0] byteMask(input logic [3:0] strb);
        byteMask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // ==========================================================================
    // Change status and interrupt
    // ==========================================================================
    assign readDo = s_axi_arvalid && s_axi_arready;
    assign readClear = readDo && ({s_axi_araddr[7:2], 2'b00} == OFF_CHANGE_IRQ_STATUS);

    // R3 read clears status
    // R20 new change beats the clear
    // R2 sticky change bits
    always_comb begin
        change_next = (readClear ? '0 : change_reg) | levelChange;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            change_reg <= RST_CHANGE;
        end else begin
            change_reg <= change_next;
        end
    end

    // R19 interrupt from status and mask
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(change_reg & mask_reg);
        end
    end
    assign changeIrq = irq_reg;

    // ==========================================================================
    // AXI4-Lite read channel
    // ==========================================================================
    assign s_axi_arready = !rValid_reg;
    assign s_axi_rvalid = rValid_reg;
    assign s_axi_rdata = rData_reg;
    assign s_axi_rresp = rResp_reg;

    // Read multiplexer; write-only registers read as zero.
    always_comb begin
        rdValue = 32'h0000_0000;
        rdHit = 1'b1;
        unique case ({s_axi_araddr[7:2], 2'b00})
            // R1 mask readback
            OFF_CHANGE_IRQ_MASK_STATUS: rdValue = mask_reg;
            OFF_CHANGE_IRQ_STATUS: rdValue = change_reg;
            OFF_OPEN_DRAIN_STATUS: rdValue = openDrain_reg;
            // R10 inverted pull-up status
            OFF_PULLUP_STATUS: rdValue = pullupOff_reg;
            // R13 function select status
            OFF_FUNCTION_SELECT_STATUS: rdValue = funcB_reg;
            // R16 direct write status
            OFF_DIRECT_WRITE_STATUS: rdValue = directWrite_reg;
            OFF_OUTPUT_LEVEL_VALUE: rdValue = outLevel_reg;
            OFF_CHANGE_IRQ_ENABLE, OFF_CHANGE_IRQ_DISABLE, OFF_OPEN_DRAIN_ENABLE,
            OFF_OPEN_DRAIN_DISABLE, OFF_PULLUP_DISABLE, OFF_PULLUP_ENABLE,
            OFF_FUNCTION_A_SELECT, OFF_FUNCTION_B_SELECT, OFF_DIRECT_WRITE_ENABLE,
            OFF_DIRECT_WRITE_DISABLE: rdValue = 32'h0000_0000;
            default: rdHit = 1'b0;
        endcase
    end

    // Data is captured on acceptance, so the status read and its clear see one value.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rValid_reg <= 1'b0;
            rData_reg <= 32'h0000_0000;
            rResp_reg <= RESP_OKAY;
        end else if (readDo) begin
            rValid_reg <= 1'b1;
            rData_reg <= rdValue;
            rResp_reg <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end else if (rValid_reg && s_axi_rready) begin
            rValid_reg <= 1'b0;
        end
    end

    // ==========================================================================
    // Pad drive
    // ==========================================================================
    // Source select: controller data when the line is under PIO, else function A or B.
    assign padData = (pioEnable & outLevel_reg) | (~pioEnable & ((funcB_reg & funcBData)
        | (~funcB_reg & funcAData)));
    assign padEn = (pioEnable & pioOutputEnable) | (~pioEnable & ((funcB_reg & funcBOutEn)
        | (~funcB_reg & funcAOutEn)));

    // R6 open drain releases high
    // R7 push-pull drives both levels
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pinOut_reg <= '0;
            pinOutEn_reg <= '0;
        end else begin
            pinOut_reg <= padData & ~openDrain_reg;
            pinOutEn_reg <= padEn & ~(openDrain_reg & padData);
        end
    end
    assign pinOut = pinOut_reg;
    assign pinOutEn = pinOutEn_reg;
    assign pullupOn = ~pullupOff_reg;

    // ==========================================================================
    // Checks
    // ==========================================================================
    sequence writeAt(logic [7:0] off);
        writeDo && ({awAddr_reg[7:2], 2'b00} == off);
    endsequence

    sequence arTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    chk_mask_readback: assert property (@(posedge clock) disable iff (!reset_n) // R1
        arTaken ##0 ({s_axi_araddr[7:2], 2'b00} == OFF_CHANGE_IRQ_MASK_STATUS)
        |=> s_axi_rvalid && s_axi_rdata == $past(mask_reg)) else $error("mask readback wrong");

    chk_change_sticky: assert property (@(posedge clock) disable iff (!reset_n) // R2
        (|levelChange) |=> ((change_reg & $past(levelChange)) == $past(levelChange)))
        else $error("change not captured");

    chk_status_clear: assert property (@(posedge clock) disable iff (!reset_n) // R3
        readClear && levelChange == '0 |=> change_reg == '0) else $error("status not cleared");

    chk_od_enable: assert property (@(posedge clock) disable iff (!reset_n) // R4
        writeAt(OFF_OPEN_DRAIN_ENABLE) |=> (openDrain_reg & $past(wBits)) == $past(wBits))
        else $error("open drain enable lost");

    chk_od_disable: assert property (@(posedge clock) disable iff (!reset_n) // R5
        writeAt(OFF_OPEN_DRAIN_DISABLE) |=> (openDrain_reg & $past(wBits)) == '0)
        else $error("open drain disable lost");

    chk_od_low_only: assert property (@(posedge clock) disable iff (!reset_n) // R6
        1'b1 |=> (pinOut & pinOutEn & $past(openDrain_reg)) == '0) else $error("open drain drove high");

    chk_pp_follow: assert property (@(posedge clock) disable iff (!reset_n) // R7
        1'b1 |=> ((pinOut ^ $past(padData)) & ~$past(openDrain_reg)) == '0) else $error("push-pull data wrong");

    chk_pullup_on: assert property (@(posedge clock) disable iff (!reset_n) // R9
        writeAt(OFF_PULLUP_ENABLE) |=> (pullupOn & $past(wBits)) == $past(wBits))
        else $error("pull-up not enabled");

    chk_func_b: assert property (@(posedge clock) disable iff (!reset_n) // R12
        writeAt(OFF_FUNCTION_B_SELECT) |=> (funcB_reg & $past(wBits)) == $past(wBits))
        else $error("function B not selected");

    chk_direct_gate: assert property (@(posedge clock) disable iff (!reset_n) // R15
        writeAt(OFF_OUTPUT_LEVEL_VALUE) |=> ((outLevel_reg ^ $past(outLevel_reg)) & ~$past(directWrite_reg)) == '0)
        else $error("blocked line changed");

    chk_irq_level: assert property (@(posedge clock) disable iff (!reset_n) // R19
        1'b1 |=> changeIrq == |($past(change_reg) & $past(mask_reg))) else $error("interrupt level wrong");

    chk_write_resp: assert property (@(posedge clock) disable iff (!reset_n)
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
endmodule // io_line_controller_upper_regs

// ### io_pin_partner.sv
// Far-side model: pad wires with pull-ups and two constant peripheral functions.
// Assumes the controller's registered pad outputs and the bench's external drivers.
module io_pin_partner
    import io_line_pkg::*;
(
    input wire logic clock,
    input wire logic [31:0] pinOut,
    input wire logic [31:0] pinOutEn,
    input wire logic [31:0] pullupOn,
    input wire logic [31:0] extLevel,
    input wire logic [31:0] extEn,
    output logic [31:0] pinIn,
    output logic [31:0] funcAData,
    output logic [31:0] funcAOutEn,
    output logic [31:0] funcBData,
    output logic [31:0] funcBOutEn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] lastLevel = 32'h0000_0000;
    // ==========
    // Wire resolution
    // released pads float
    // An unpulled released pad holds the inverse of its last driven level.
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (pinOutEn[i]) begin
                pinIn[i] = pinOut[i];
            end else if (extEn[i]) begin
                pinIn[i] = extLevel[i];
            end else if (pullupOn[i]) begin
                pinIn[i] = 1'h1;
            end else begin
                pinIn[i] = ~lastLevel[i];
            end
        end
    end
    always @(posedge clock) lastLevel <= pinIn ^ ~(pinOutEn | extEn | pullupOn);
    // Distinct patterns make it plain which function reaches a pad.
    assign funcAData = 32'hAAAA_AAAA;
    assign funcBData = 32'h5555_5555;
    assign funcAOutEn = 32'hFFFF_FFFF;
    assign funcBOutEn = 32'hFFFF_FFFF;
endmodule // io_pin_partner

// ### io_line_controller_upper_regs_test.sv
// Self-checking bench for the upper I/O register group over AXI4-Lite.
// Assumes the pad partner model and a 10 MHz clock.
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t got %h expected %h", $time, a, b); end end
module io_line_controller_upper_regs_test
    import io_line_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'h0, reset_n = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, extLevel = 32'h0000_0000, extEn = 32'h0000_0000;
    logic [31:0] pioEnable = 32'h7FFF_FFFF, pioOutputEnable = 32'h0000_FFFF;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, changeIrq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, pinIn, pinOut, pinOutEn, pullupOn, lineLevel, funcAData, funcAOutEn, funcBData, funcBOutEn;
    int errors = 0, compares = 0;
    io_line_controller_upper_regs u_dut (.clock, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .pinIn, .pinOut, .pinOutEn, .pullupOn, .lineLevel, .pioEnable, .pioOutputEnable,
        .funcAData, .funcAOutEn, .funcBData, .funcBOutEn, .changeIrq);
    io_pin_partner u_pins (.clock, .pinOut, .pinOutEn, .pullupOn, .extLevel, .extEn, .pinIn,
        .funcAData, .funcAOutEn, .funcBData, .funcBOutEn);
    // ==========
    // Bus tasks
    // Answers are read at the rising edge, before that edge's updates land.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clock);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        `CHK(s_axi_bresp, er)
    endtask
    // Read data is judged only on an OKAY answer.
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clock);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        `CHK(s_axi_rresp, er)
        if (er === RESP_OKAY) `CHK(s_axi_rdata, ed)
    endtask
    // ==========
    // Scenarios
    task automatic t_setclr();
        logic [7:0] setOff[5] = '{OFF_CHANGE_IRQ_ENABLE, OFF_OPEN_DRAIN_ENABLE, OFF_PULLUP_DISABLE,
            OFF_FUNCTION_B_SELECT, OFF_DIRECT_WRITE_ENABLE};
        logic [7:0] clrOff[5] = '{OFF_CHANGE_IRQ_DISABLE, OFF_OPEN_DRAIN_DISABLE, OFF_PULLUP_ENABLE,
            OFF_FUNCTION_A_SELECT, OFF_DIRECT_WRITE_DISABLE};
        logic [7:0] stsOff[5] = '{OFF_CHANGE_IRQ_MASK_STATUS, OFF_OPEN_DRAIN_STATUS, OFF_PULLUP_STATUS,
            OFF_FUNCTION_SELECT_STATUS, OFF_DIRECT_WRITE_STATUS};
        for (int k = 0; k < 5; k++) begin
            rd(stsOff[k], 32'h0000_0000, RESP_OKAY);
            wr(setOff[k], 32'h0000_00F0, RESP_OKAY);
            rd(stsOff[k], 32'h0000_00F0, RESP_OKAY);
            wr(setOff[k], 32'h0000_000F, RESP_OKAY);
            rd(stsOff[k], 32'h0000_00FF, RESP_OKAY);
            wr(clrOff[k], 32'h0000_0030, RESP_OKAY);
            rd(stsOff[k], 32'h0000_00CF, RESP_OKAY);
            if (k == 2) `CHK(pullupOn, 32'hFFFF_FF30)
            wr(clrOff[k], 32'hFFFF_FFFF, RESP_OKAY);
            rd(stsOff[k], 32'h0000_0000, RESP_OKAY);
        end
        $display("set and clear test done");
    endtask
    task automatic t_pins();
        s_axi_wstrb <= 4'h1;
        wr(OFF_DIRECT_WRITE_ENABLE, 32'h0000_FFFF, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        wr(OFF_OUTPUT_LEVEL_VALUE, 32'hFFFF_FFFF, RESP_OKAY);
        rd(OFF_OUTPUT_LEVEL_VALUE, 32'h0000_00FF, RESP_OKAY);
        repeat (2) @(negedge clock);
        `CHK(pinOutEn, 32'h8000_FFFF)
        `CHK(pinOut & pinOutEn, 32'h8000_00FF)
        wr(OFF_FUNCTION_B_SELECT, 32'h8000_0000, RESP_OKAY);
        rd(OFF_FUNCTION_SELECT_STATUS, 32'h8000_0000, RESP_OKAY);
        wr(OFF_OPEN_DRAIN_ENABLE, 32'h0000_000F, RESP_OKAY);
        repeat (4) @(negedge clock);
        `CHK(pinOutEn, 32'h8000_FFF0)
        `CHK(pinOut & pinOutEn, 32'h0000_00F0)
        `CHK(lineLevel, 32'h7FFF_00FF)
        wr(OFF_OPEN_DRAIN_DISABLE, 32'hFFFF_FFFF, RESP_OKAY);
        wr(OFF_FUNCTION_A_SELECT, 32'hFFFF_FFFF, RESP_OKAY);
        $display("pin drive test done");
    endtask
    task automatic t_change();
        extEn <= 32'h0010_0000;
        repeat (6) @(negedge clock);
        rd(OFF_CHANGE_IRQ_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
        rd(OFF_CHANGE_IRQ_STATUS, 32'h0000_0000, RESP_OKAY);
        wr(OFF_CHANGE_IRQ_ENABLE, 32'h0010_0000, RESP_OKAY);
        rd(OFF_CHANGE_IRQ_MASK_STATUS, 32'h0010_0000, RESP_OKAY);
        `CHK(changeIrq, 1'h0)
        extLevel <= 32'h0010_0000;
        repeat (5) @(negedge clock);
        `CHK(changeIrq, 1'h1)
        rd(OFF_CHANGE_IRQ_STATUS, 32'h0010_0000, RESP_OKAY);
        @(negedge clock);
        `CHK(changeIrq, 1'h0)
        wr(OFF_CHANGE_IRQ_DISABLE, 32'h0010_0000, RESP_OKAY);
        extLevel <= 32'h0000_0000;
        repeat (5) @(negedge clock);
        `CHK(changeIrq, 1'h0)
        rd(OFF_CHANGE_IRQ_STATUS, 32'h0010_0000, RESP_OKAY);
        $display("change status test done");
    endtask
    // Unmapped places answer with an error; the wrong direction is harmless.
    task automatic t_bus();
        rd(8'h1C, 32'h0000_0000, RESP_SLVERR);
        wr(8'h1C, 32'hFFFF_FFFF, RESP_SLVERR);
        rd(OFF_OPEN_DRAIN_ENABLE, 32'h0000_0000, RESP_OKAY);
        wr(OFF_OPEN_DRAIN_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
        rd(OFF_OPEN_DRAIN_STATUS, 32'h0000_0000, RESP_OKAY);
        $display("bus answer test done");
    endtask
    task automatic end_sim();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ==========
    // Clock, sequence and watchdog
    initial forever #50 clock = ~clock;
    initial begin
        repeat (6) @(posedge clock);
        reset_n <= 1'h1;
        t_setclr();
        t_pins();
        t_change();
        t_bus();
        end_sim();
    end
    // The run needs well under a thousand cycles; five thousand means a hang.
    initial begin
        repeat (5000) @(posedge clock);
        errors++;
        end_sim();
    end
endmodule // io_line_controller_upper_regs_test
